/* File: sfr_pkg.sv */
// constants, field layouts, opcodes, timing counts and state types for the serial flash read path
// assumes a 20 MHz pclk on both ends; the link clock is made by the host from pclk
package sfr_pkg;

	// timing
	localparam int PCLK_NS      = 50;
	localparam int SCLK_HALF_NS = 200;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS + PCLK_NS - 1) / PCLK_NS;
	localparam logic [2:0] SCLK_HALF_LAST = 3'(SCLK_HALF_CYC - 1);
	localparam int INT_CYCLE_NS  = 1000;
	localparam int INT_CYCLE_CYC = INT_CYCLE_NS / PCLK_NS;
	localparam logic [15:0] INT_CYCLE_LOAD = 16'(INT_CYCLE_CYC);

	// command opcodes
	localparam logic [7:0] CMD_PLAIN_READ = 8'h03;
	localparam logic [7:0] CMD_FAST_READ  = 8'h0B;
	localparam logic [7:0] DUAL_LANE_FETCH_CMD     = 8'h3B;
	localparam logic [7:0] SECTOR_LOCK_QUERY_CMD   = 8'hE8;
	localparam logic [7:0] ONETIME_AREA_FETCH_CMD  = 8'h4B;

	// link framing: CMD_LAST, ADDR_LAST and DUMMY_LAST are bits minus one; TX_BITS_PLAIN and TX_BITS_DUMMY are whole bits
	localparam logic [4:0] CMD_LAST   = 5'h07;
	localparam logic [4:0] ADDR_LAST  = 5'h17;
	localparam logic [4:0] DUMMY_LAST = 5'h07;
	localparam logic [5:0] TX_BITS_PLAIN = 6'h20;
	localparam logic [5:0] TX_BITS_DUMMY = 6'h28;

	// array geometry: A23 is not used
	localparam int ARRAY_AW    = 23;
	localparam int ARRAY_BYTES = 2 ** ARRAY_AW;
	localparam int SECTOR_LSB  = 16;
	localparam int NUM_SECTORS = 128;
	localparam logic [6:0] OTP_LAST = 7'h40;

	// sector protection flag layout
	localparam int LOCK_WLOCK_BIT = 0;
	localparam int LOCK_LDOWN_BIT = 1;
	localparam logic [NUM_SECTORS-1:0] LOCK_RESET = '0;

	// synchroniser reset levels: select idles high, device lane zero resets low, host lanes reset high
	localparam logic [2:0] DEV_SYNC_RST  = 3'h4;
	localparam logic [1:0] HOST_SYNC_RST = 2'h3;

	// host controller register map on apb
	localparam logic [11:0] REG_CTRL   = 12'h000;
	localparam logic [11:0] REG_ADDR   = 12'h004;
	localparam logic [11:0] REG_LEN    = 12'h008;
	localparam logic [11:0] REG_STATUS = 12'h00C;
	localparam logic [11:0] REG_RXDATA = 12'h010;
	localparam int CTRL_START_BIT  = 8;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_READY_BIT  = 1;

	typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} sfr_dstate_e;
	typedef enum logic [1:0] {K_ARRAY, K_LOCK, K_OTP} sfr_kind_e;
	typedef enum logic [1:0] {H_IDLE, H_TX, H_RX} sfr_hstate_e;

endpackage

/* File: sfr_link_if.sv */
// serial link between the host controller and the flash read path
// lanes are resolved here from the output enables; an undriven lane reads high
`timescale 1ns/1ps
`default_nettype none
interface sfr_link_if;
	logic select_n;
	logic sclk;
	logic host_lane0_o;
	logic host_lane0_oe_n;
	logic dev_lane0_o;
	logic dev_lane0_oe_n;
	logic dev_lane1_o;
	logic dev_lane1_oe_n;
	logic serial_lane_zero;
	logic serial_lane_one;

	// host wins lane zero if both drive; the protocol never lets that happen
	assign serial_lane_zero = !host_lane0_oe_n ? host_lane0_o :
	                          (!dev_lane0_oe_n ? dev_lane0_o : 1'b1);
	assign serial_lane_one  = !dev_lane1_oe_n ? dev_lane1_o : 1'b1;

	modport host (
		output select_n, sclk, host_lane0_o, host_lane0_oe_n,
		input  serial_lane_zero, serial_lane_one
	);
	modport dev (
		input  select_n, sclk, serial_lane_zero,
		output dev_lane0_o, dev_lane0_oe_n, dev_lane1_o, dev_lane1_oe_n
	);
endinterface
`default_nettype wire

/* File: sfr_sync.sv */
// two flip-flop synchroniser, one chain per bit
// assumes each bit is an independent level; no bus coherence is promised
`timescale 1ns/1ps
`default_nettype none
module sfr_sync #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				meta[i] <= RST[i];
				q[i]    <= RST[i];
			end else begin
				meta[i] <= d[i];
				q[i]    <= meta[i];
			end
		end
	end
endmodule
`default_nettype wire

/* File: sfr_dev.sv */
// flash read path: decodes the five read commands and streams bytes out
// assumes the link clock is slow against pclk (at least 8 pclk per period)
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module sfr_dev
	import sfr_pkg::*;
(
	input  wire logic                pclk,
	input  wire logic                presetn,
	sfr_link_if.dev                  link,
	input  wire logic                mem_load_en,
	input  wire logic [ARRAY_AW-1:0] mem_load_addr,
	input  wire logic [7:0]          mem_load_data,
	input  wire logic                otp_load_en,
	input  wire logic [6:0]          otp_load_addr,
	input  wire logic [7:0]          otp_load_data,
	input  wire logic                lock_wr_en,
	input  wire logic [6:0]          lock_wr_sector,
	input  wire logic [1:0]          lock_wr_data,
	output logic                     internal_cycle_active,
	output logic                     mem_load_refused,
	output logic                     lock_wr_refused
);
	logic [2:0]          s_q;
	logic                sel_n_s;
	logic                sclk_s;
	logic                din_s;
	logic                sclk_d;
	logic                rise;
	logic                fall;
	sfr_dstate_e         state;
	logic [4:0]          bit_cnt;
	logic [7:0]          cmd_sh;
	logic [23:0]         addr_sh;
	logic [7:0]          next_cmd;
	sfr_kind_e           kind;
	sfr_kind_e           next_kind;
	logic                dual;
	logic                need_dummy;
	logic                cmd_known;
	logic                cmd_dual;
	logic                cmd_dummy;
	logic                addr_done;
	logic [ARRAY_AW-1:0] start_addr;
	logic [ARRAY_AW-1:0] rd_addr;
	logic [ARRAY_AW-1:0] next_addr;
	logic [6:0]          otp_idx;
	logic [7:0]          fetched;
	logic [7:0]          sh;
	logic [2:0]          ocnt;
	logic                l0;
	logic                l1;
	logic                l0_oe_n;
	logic                l1_oe_n;
	logic [7:0]          mem [0:ARRAY_BYTES-1];
	logic [7:0]          otp [0:64];
	logic [NUM_SECTORS-1:0] wlock;
	logic [NUM_SECTORS-1:0] ldown;
	logic [6:0]          rd_sec;
	logic                mem_accept;
	logic                lock_accept;
	logic [15:0]         cyc_cnt;

	// link pins are asynchronous to pclk
	sfr_sync #(
		.W   (3),
		.RST (DEV_SYNC_RST)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({link.select_n, link.sclk, link.serial_lane_zero}),
		.q       (s_q)
	);
	assign sel_n_s = s_q[2];
	assign sclk_s  = s_q[1];
	assign din_s   = s_q[0];

	// edge finder on the synchronised link clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_d <= 1'b0;
		end else begin
			sclk_d <= sclk_s;
		end
	end
	assign rise = sclk_s & ~sclk_d & ~sel_n_s;
	assign fall = ~sclk_s & sclk_d & ~sel_n_s;

	// command decode on the byte being completed
	assign next_cmd = {cmd_sh[6:0], din_s};
	always_comb begin
		cmd_known = 1'b1;
		cmd_dual  = 1'b0;
		cmd_dummy = 1'b0;
		next_kind = K_ARRAY;
		unique case (next_cmd)
			CMD_PLAIN_READ: ;
			CMD_FAST_READ: cmd_dummy = 1'b1;
			DUAL_LANE_FETCH_CMD: begin
				cmd_dummy = 1'b1;
				cmd_dual  = 1'b1;
			end
			SECTOR_LOCK_QUERY_CMD: next_kind = K_LOCK;
			ONETIME_AREA_FETCH_CMD: begin
				cmd_dummy = 1'b1;
				next_kind = K_OTP;
			end
			default: cmd_known = 1'b0;
		endcase
	end

	// framing: command, address and dummy bits are taken on rising edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= ST_CMD;
			bit_cnt    <= 5'h00;
			cmd_sh     <= 8'h00;
			addr_sh    <= 24'h00_0000;
			kind       <= K_ARRAY;
			dual       <= 1'b0;
			need_dummy <= 1'b0;
		end else if (sel_n_s) begin
			state   <= ST_CMD;
			bit_cnt <= 5'h00;
		end else if (rise) begin
			unique case (state)
				ST_CMD: begin
					cmd_sh <= next_cmd;
					if (bit_cnt == CMD_LAST) begin
						bit_cnt    <= 5'h00;
						kind       <= next_kind;
						dual       <= cmd_dual;
						need_dummy <= cmd_dummy;
						// a busy device drops the frame and leaves the cycle alone
						if (internal_cycle_active || !cmd_known) begin
							state <= ST_IGNORE;
						end else begin
							state <= ST_ADDR;
						end
					end else begin
						bit_cnt <= bit_cnt + 5'h01;
					end
				end
				ST_ADDR: begin
					addr_sh <= {addr_sh[22:0], din_s};
					if (bit_cnt == ADDR_LAST) begin
						bit_cnt <= 5'h00;
						state   <= need_dummy ? ST_DUMMY : ST_DATA;
					end else begin
						bit_cnt <= bit_cnt + 5'h01;
					end
				end
				ST_DUMMY: begin
					// dummy bits are counted and thrown away
					if (bit_cnt == DUMMY_LAST) begin
						bit_cnt <= 5'h00;
						state   <= ST_DATA;
					end else begin
						bit_cnt <= bit_cnt + 5'h01;
					end
				end
				ST_DATA, ST_IGNORE: ;
			endcase
		end
	end

	assign addr_done  = rise && (state == ST_ADDR) && (bit_cnt == ADDR_LAST);
	assign start_addr = {addr_sh[21:0], din_s}; // top bit dropped

	// byte source and the address step that follows it
	assign rd_sec  = rd_addr[ARRAY_AW-1:SECTOR_LSB];
	assign otp_idx = (rd_addr[6:0] > OTP_LAST) ? OTP_LAST : rd_addr[6:0];
	always_comb begin
		fetched   = mem[rd_addr];
		next_addr = ARRAY_AW'(rd_addr + 1'b1);
		unique case (kind)
			K_ARRAY: ;
			K_LOCK: begin
				fetched   = {6'h00, ldown[rd_sec], wlock[rd_sec]};
				next_addr = rd_addr;
			end
			K_OTP: begin
				fetched   = otp[otp_idx];
				// no rollover: the last byte repeats
				next_addr = (otp_idx == OTP_LAST) ? rd_addr :
				            {rd_addr[ARRAY_AW-1:7], otp_idx + 7'h01};
			end
			default: ;
		endcase
	end

	// output shifter: bits change on falling edges, msb first
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_addr <= '0;
			sh      <= 8'h00;
			ocnt    <= 3'h0;
			l0      <= 1'b0;
			l1      <= 1'b0;
			l0_oe_n <= 1'b1;
			l1_oe_n <= 1'b1;
		end else if (sel_n_s || state != ST_DATA) begin
			l0_oe_n <= 1'b1;
			l1_oe_n <= 1'b1;
			ocnt    <= 3'h0;
			if (addr_done) begin
				rd_addr <= start_addr;
			end
		end else if (fall) begin
			l1_oe_n <= 1'b0;
			l0_oe_n <= ~dual;
			if (ocnt == 3'h0) begin
				l1      <= fetched[7];
				l0      <= fetched[6];
				sh      <= dual ? {fetched[5:0], 2'b00} : {fetched[6:0], 1'b0};
				ocnt    <= dual ? 3'h3 : 3'h7;
				rd_addr <= next_addr;
			end else begin
				l1   <= sh[7];
				l0   <= sh[6];
				sh   <= dual ? {sh[5:0], 2'b00} : {sh[6:0], 1'b0};
				ocnt <= ocnt - 3'h1;
			end
		end
	end
	assign link.dev_lane0_o    = l0;
	assign link.dev_lane0_oe_n = l0_oe_n;
	assign link.dev_lane1_o    = l1;
	assign link.dev_lane1_oe_n = l1_oe_n;

	// sector protection flags; power-up clears lock-down, nothing else does
	assign lock_accept = lock_wr_en & ~ldown[lock_wr_sector];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wlock           <= LOCK_RESET;
			ldown           <= LOCK_RESET;
			lock_wr_refused <= 1'b0;
		end else begin
			lock_wr_refused <= lock_wr_en & ~lock_accept;
			if (lock_accept) begin
				wlock[lock_wr_sector] <= lock_wr_data[LOCK_WLOCK_BIT];
				ldown[lock_wr_sector] <= lock_wr_data[LOCK_LDOWN_BIT];
			end
		end
	end

	// array loads are programs: refused in a locked sector or mid-cycle
	assign mem_accept = mem_load_en & ~internal_cycle_active &
	                    ~wlock[mem_load_addr[ARRAY_AW-1:SECTOR_LSB]];
	always_ff @(posedge pclk) begin
		if (mem_accept) begin
			mem[mem_load_addr] <= mem_load_data;
		end
		if (otp_load_en && otp_load_addr <= OTP_LAST) begin
			otp[otp_load_addr] <= otp_load_data;
		end
	end

	// self-timed cycle started by an accepted array load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc_cnt               <= 16'h0000;
			internal_cycle_active <= 1'b0;
			mem_load_refused      <= 1'b0;
		end else begin
			mem_load_refused <= mem_load_en & ~mem_accept;
			if (mem_accept) begin
				cyc_cnt               <= INT_CYCLE_LOAD;
				internal_cycle_active <= 1'b1;
			end else if (cyc_cnt != 16'h0000) begin
				cyc_cnt               <= cyc_cnt - 16'h0001;
				internal_cycle_active <= (cyc_cnt != 16'h0001);
			end
		end
	end
endmodule
`default_nettype wire

/* File: sfr_host.sv */
// host controller: apb registers in, serial read frames out on the link
// assumes zero-wait apb; the link clock is divided down from pclk here
`timescale 1ns/1ps
`default_nettype none
module sfr_host
	import sfr_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	sfr_link_if.host         link
);
	sfr_hstate_e state;
	logic [7:0]  cmd_reg;
	logic [23:0] addr_reg;
	logic [15:0] len_reg;
	logic [7:0]  rx_data;
	logic        data_ready;
	logic        wr;
	logic        rd_setup;
	logic        start;
	logic        pop;
	logic [7:0]  op_now;
	logic        is_dual;
	logic        is_dummy;
	logic [1:0]  lanes_s;
	logic [2:0]  phase;
	logic [39:0] tx_sh;
	logic [5:0]  tx_left;
	logic [7:0]  rx_sh;
	logic [2:0]  step;
	logic [15:0] bytes_left;
	logic        step_last;
	logic        edge_due;
	logic        stall;
	logic        got_byte;
	logic [7:0]  rx_byte;
	logic        sclk;
	logic        select_n;
	logic        lane0;
	logic        lane0_oe_n;

	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign wr       = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign pop      = psel & penable & ~pwrite & (paddr == REG_RXDATA);
	assign start    = wr && (paddr == REG_CTRL) && pwdata[CTRL_START_BIT] &&
	                  (state == H_IDLE) && (len_reg != 16'h0000);
	// the start write carries its own opcode; cmd_reg only catches up at that edge
	assign op_now   = start ? pwdata[7:0] : cmd_reg;
	assign is_dual  = (op_now == DUAL_LANE_FETCH_CMD);
	assign is_dummy = (op_now == CMD_FAST_READ) || is_dual ||
	                  (op_now == ONETIME_AREA_FETCH_CMD);

	// order registers; writes to them mid-frame are ignored so a frame cannot tear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg  <= 8'h00;
			addr_reg <= 24'h00_0000;
			len_reg  <= 16'h0000;
		end else if (wr && state == H_IDLE) begin
			if (paddr == REG_CTRL) cmd_reg <= pwdata[7:0];
			if (paddr == REG_ADDR) addr_reg <= pwdata[23:0];
			if (paddr == REG_LEN) len_reg <= pwdata[15:0];
		end
	end

	// read data captured in the setup cycle so the access phase needs no wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			unique case (paddr)
				REG_CTRL:   prdata <= {24'h00_0000, cmd_reg};
				REG_ADDR:   prdata <= {8'h00, addr_reg};
				REG_LEN:    prdata <= {16'h0000, len_reg};
				REG_STATUS: prdata <= {30'h0000_0000, data_ready, state != H_IDLE};
				REG_RXDATA: prdata <= {24'h00_0000, rx_data};
				default:    prdata <= 32'h0000_0000;
			endcase
		end
	end

	// lanes from the device are asynchronous to pclk
	sfr_sync #(
		.W   (2),
		.RST (HOST_SYNC_RST)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.d       ({link.serial_lane_one, link.serial_lane_zero}),
		.q       (lanes_s)
	);

	assign edge_due  = (phase == SCLK_HALF_LAST);
	assign step_last = is_dual ? (step == 3'h3) : (step == 3'h7);
	// sample at the end of the high half, well after the device's fall update
	assign rx_byte   = is_dual ? {rx_sh[5:0], lanes_s[1], lanes_s[0]} :
	                             {rx_sh[6:0], lanes_s[1]};
	// back-pressure: hold sclk high until software has taken the last byte
	assign stall     = (state == H_RX) && sclk && step_last && data_ready;
	assign got_byte  = (state == H_RX) && sclk && edge_due && step_last && !stall;

	// frame sequencer: mode 0, lane zero changes with the falling edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state      <= H_IDLE;
			phase      <= 3'h0;
			sclk       <= 1'b0;
			select_n   <= 1'b1;
			lane0      <= 1'b0;
			lane0_oe_n <= 1'b1;
			tx_sh      <= '0;
			tx_left    <= 6'h00;
			rx_sh      <= 8'h00;
			step       <= 3'h0;
			bytes_left <= 16'h0000;
		end else if (state == H_IDLE) begin
			sclk <= 1'b0;
			if (start) begin
				state      <= H_TX;
				select_n   <= 1'b0;
				tx_sh      <= {op_now, addr_reg, 8'h00};
				lane0      <= op_now[7];
				lane0_oe_n <= 1'b0;
				tx_left    <= (is_dummy ? TX_BITS_DUMMY : TX_BITS_PLAIN) - 6'h01;
				phase      <= 3'h0;
				step       <= 3'h0;
				bytes_left <= len_reg;
			end
		end else if (!edge_due) begin
			phase <= phase + 3'h1;
		end else if (!sclk) begin
			sclk  <= 1'b1;
			phase <= 3'h0;
		end else if (state == H_TX) begin
			sclk  <= 1'b0;
			phase <= 3'h0;
			if (tx_left == 6'h00) begin
				state      <= H_RX;
				lane0_oe_n <= 1'b1;
			end else begin
				tx_sh   <= {tx_sh[38:0], 1'b0};
				lane0   <= tx_sh[38];
				tx_left <= tx_left - 6'h01;
			end
		end else if (!stall) begin
			rx_sh <= rx_byte;
			phase <= 3'h0;
			step  <= step_last ? 3'h0 : step + 3'h1;
			if (step_last && bytes_left == 16'h0001) begin
				state    <= H_IDLE;
				select_n <= 1'b1;
			end else begin
				sclk <= 1'b0;
				if (step_last) bytes_left <= bytes_left - 16'h0001;
			end
		end
	end

	// received byte and its flag; a new byte beats a same-cycle pop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_data    <= 8'h00;
			data_ready <= 1'b0;
		end else if (got_byte) begin
			rx_data    <= rx_byte;
			data_ready <= 1'b1;
		end else if (pop) begin
			data_ready <= 1'b0;
		end
	end

	assign link.sclk            = sclk;
	assign link.select_n        = select_n;
	assign link.host_lane0_o    = lane0;
	assign link.host_lane0_oe_n = lane0_oe_n;
endmodule
`default_nettype wire

/* File: sfr_checker.sv */
// link checks between the host controller and the flash read path
// assumes pclk samples every link signal; a free lane resolves high
`timescale 1ns/1ps
`default_nettype none
module sfr_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic select_n,
	input wire logic sclk,
	input wire logic host_lane0_oe_n,
	input wire logic dev_lane0_oe_n,
	input wire logic dev_lane1_o,
	input wire logic dev_lane1_oe_n,
	input wire logic serial_lane_one
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// device release lags select by its two-flop sync plus a register
	sequence s_idle;
		select_n [*4];
	endsequence
	sequence s_dev_talks;
		!dev_lane1_oe_n && $past(!dev_lane1_oe_n);
	endsequence

	a_idle_released: assert property (s_idle |-> dev_lane0_oe_n && dev_lane1_oe_n)
		else $error("device drives a lane while deselected");
	a_no_contention: assert property (!(!host_lane0_oe_n && !dev_lane0_oe_n))
		else $error("both ends drive lane zero");
	a_quiet_command: assert property (!host_lane0_oe_n |-> dev_lane0_oe_n && dev_lane1_oe_n)
		else $error("device drives during command or address");
	a_sclk_idle: assert property (select_n [*2] |-> !sclk)
		else $error("link clock runs outside a frame");
	a_rise_selected: assert property ($rose(sclk) |-> !select_n)
		else $error("link clock rises while deselected");
	a_frame_opens: assert property ($fell(select_n) |-> !host_lane0_oe_n && !sclk)
		else $error("frame opens without host driving lane zero");
	a_dual_pairs: assert property (!dev_lane0_oe_n |-> !dev_lane1_oe_n)
		else $error("lane zero driven without lane one");
	a_fall_launch: assert property (s_dev_talks ##0 $changed(dev_lane1_o) |-> !sclk)
		else $error("output lane changes while link clock is high");
	a_open_released: assert property ($fell(select_n) |-> dev_lane0_oe_n && dev_lane1_oe_n && serial_lane_one)
		else $error("device still drives a lane when a frame opens");
endmodule
`default_nettype wire

/* File: tb.sv */
// self-checking bench: host controller and flash read path on one link
// assumes a 20 MHz pclk; every byte read is compared with a bench model, or with 255 in a dropped frame
`timescale 1ns/1ps
`default_nettype none
module tb
	import sfr_pkg::*;
;
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic                psel = 1'b0;
	logic                penable = 1'b0;
	logic                pwrite = 1'b0;
	logic [11:0]         paddr = '0;
	logic [31:0]         pwdata = '0;
	logic [31:0]         prdata;
	logic                pready;
	logic                pslverr;
	logic                ld_en = 1'b0;
	logic [ARRAY_AW-1:0] ld_addr = '0;
	logic [7:0]          ld_data = '0;
	logic                otp_en = 1'b0;
	logic [6:0]          otp_addr = '0;
	logic [7:0]          otp_data = '0;
	logic                lk_en = 1'b0;
	logic [6:0]          lk_sec = '0;
	logic [1:0]          lk_data = '0;
	logic                busy_flag;
	logic                mref;
	logic                lref;
	int                  fail_count = 0;
	int                  comparisons = 0;
	int                  cyc = 0;
	int                  act_cnt = 0;
	int                  mref_cnt = 0;
	int                  lref_cnt = 0;
	int unsigned         seed = 67;
	int                  mem [int];
	int                  lock [128];
	int                  otp [65];
	int                  ops [3] = '{CMD_PLAIN_READ, CMD_FAST_READ, DUAL_LANE_FETCH_CMD};

	sfr_link_if link ();
	sfr_host u_sfr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	sfr_dev u_sfr_dev (.pclk(pclk), .presetn(presetn), .link(link), .mem_load_en(ld_en),
		.mem_load_addr(ld_addr), .mem_load_data(ld_data), .otp_load_en(otp_en),
		.otp_load_addr(otp_addr), .otp_load_data(otp_data), .lock_wr_en(lk_en),
		.lock_wr_sector(lk_sec), .lock_wr_data(lk_data), .internal_cycle_active(busy_flag),
		.mem_load_refused(mref), .lock_wr_refused(lref));
	sfr_checker u_sfr_checker (.pclk(pclk), .presetn(presetn), .select_n(link.select_n),
		.sclk(link.sclk), .host_lane0_oe_n(link.host_lane0_oe_n),
		.dev_lane0_oe_n(link.dev_lane0_oe_n), .dev_lane1_o(link.dev_lane1_o),
		.dev_lane1_oe_n(link.dev_lane1_oe_n), .serial_lane_one(link.serial_lane_one));

	// 50 ns clock
	initial begin
		forever #25 pclk = ~pclk;
	end

	// cycle, busy and refusal counters; the ceiling cuts a hang short
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		act_cnt <= act_cnt + int'(busy_flag === 1'b1);
		mref_cnt <= mref_cnt + int'(mref === 1'b1);
		lref_cnt <= lref_cnt + int'(lref === 1'b1);
		if (cyc == 60000) begin
			fail_count++;
			print_verdict();
		end
	end

	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return int'(seed & 32'h0000_00FF);
	endfunction

	// expected byte i of a read; otp index saturates; unknown opcodes read the idle-high lane
	function automatic int model(int op, int a, int i);
		int k;
		k = (a & 127) + i;
		if (op != CMD_PLAIN_READ && op != CMD_FAST_READ && op != DUAL_LANE_FETCH_CMD &&
		    op != SECTOR_LOCK_QUERY_CMD && op != ONETIME_AREA_FETCH_CMD) return 255;
		if (op == SECTOR_LOCK_QUERY_CMD) return lock[(a >> 16) & 127];
		if (op == ONETIME_AREA_FETCH_CMD) return otp[k > 64 ? 64 : k];
		return mem[(a + i) & 32'h007F_FFFF];
	endfunction

	task automatic check(string what, int exp, logic [31:0] got);
		comparisons++;
		if (got !== 32'(exp)) begin
			fail_count++;
			$display("[ERR] %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// one apb transfer; an idle cycle separates transfers so no strobe toggles twice
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, output logic [31:0] q);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		check("pslverr", 0, 32'(pslverr));
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic w(logic [11:0] a, logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask

	task automatic pulse(int a, int d);
		@(posedge pclk);
		ld_en <= 1'b1;
		ld_addr <= ARRAY_AW'(a);
		ld_data <= 8'(d);
		@(posedge pclk);
		ld_en <= 1'b0;
	endtask

	task automatic load(int a, int d, int ok);
		int c0;
		int r0;
		c0 = act_cnt;
		r0 = mref_cnt;
		pulse(a, d);
		repeat (30) @(posedge pclk);
		check("cycle_len", ok ? INT_CYCLE_CYC : 0, act_cnt - c0);
		check("load_refused", int'(!ok), mref_cnt - r0);
		if (ok) mem[a] = d;
	endtask

	task automatic lk(int s, int d, int ok);
		int r0;
		r0 = lref_cnt;
		@(posedge pclk);
		lk_en <= 1'b1;
		lk_sec <= 7'(s);
		lk_data <= 2'(d);
		@(posedge pclk);
		lk_en <= 1'b0;
		repeat (4) @(posedge pclk);
		check("lock_refused", int'(!ok), lref_cnt - r0);
		if (ok) lock[s] = d;
	endtask

	// frame of n bytes; bz lands an internal cycle on the command's last bit
	task automatic rd(int op, int a, int n, int bz);
		logic [31:0] q;
		int c0;
		w(REG_ADDR, 32'(a));
		w(REG_LEN, 32'(n));
		w(REG_CTRL, 32'h0000_0100 | 32'(op));
		c0 = act_cnt;
		if (bz) begin
			repeat (45) @(posedge pclk);
			pulse(5, 8'hA5);
			mem[5] = 8'hA5;
		end
		for (int i = 0; i < n; i++) begin
			do apb(1'b0, REG_STATUS, 0, q); while (q[STAT_READY_BIT] !== 1'b1);
			apb(1'b0, REG_RXDATA, 0, q);
			check("rx_byte", bz ? 255 : model(op, a, i), q[7:0]);
		end
		if (bz) check("busy_cycle", INT_CYCLE_CYC, act_cnt - c0);
	endtask

	task automatic print_verdict();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		logic [31:0] q;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 12'h020, 0, q);
		check("unmapped", 0, q);
		apb(1'b0, REG_STATUS, 0, q);
		check("status_idle", 0, q);
		for (int k = 0; k < 4; k++) load((32'h007F_FFFE + k) & 32'h007F_FFFF, rnd(), 1);
		foreach (ops[k]) rd(ops[k], 32'h00FF_FFFE, 4, 0);
		for (int i = 0; i < 65; i++) begin
			@(posedge pclk);
			otp_en <= 1'b1;
			otp_addr <= 7'(i);
			otp[i] = rnd();
			otp_data <= 8'(otp[i]);
		end
		@(posedge pclk);
		otp_en <= 1'b0;
		rd(ONETIME_AREA_FETCH_CMD, 32'h0012_343E, 5, 0);
		rd(ONETIME_AREA_FETCH_CMD, 32'h0000_0050, 2, 0);
		lk(127, 1, 1);
		rd(SECTOR_LOCK_QUERY_CMD, 32'h007F_1234, 2, 0);
		load(32'h007F_FFFF, 8'h5A, 0);
		rd(CMD_PLAIN_READ, 32'h007F_FFFF, 1, 0);
		lk(127, 3, 1);
		lk(127, 0, 0);
		rd(SECTOR_LOCK_QUERY_CMD, 32'h007F_0000, 1, 0);
		rd(CMD_PLAIN_READ, 0, 2, 1);
		rd(CMD_PLAIN_READ, 5, 1, 0);
		rd(8'h00, 0, 1, 0);
		print_verdict();
	end
endmodule
`default_nettype wire
